// *** rtl/imt_map.svh ***
`ifndef IMT_MAP_SVH
`define IMT_MAP_SVH

// register offsets
`define IMT_FAN_MASK_ADDR    8'h1A
`define IMT_MISC_MASK_ADDR   8'h1B
`define IMT_IO_LOW_MASK_ADDR 8'h1C
`define IMT_IO_HIGH_MASK_ADDR 8'h1D
`define IMT_TRIM_ADDR        8'h1E
`define IMT_READING_ADDR     8'h1F

// reset values
`define IMT_MASK_RST    8'h00
`define IMT_TRIM_RST    8'h00
`define IMT_READING_RST 8'h00
`define IMT_UNMAPPED_RD 8'h00

// misc mask field positions
`define IMT_MISC_DIE_TEMP_BIT  0
`define IMT_MISC_BATTERY_BIT   1
`define IMT_MISC_ANALOG_INPUT_8_BIT      2
`define IMT_MISC_OVERHEAT_BIT  3
`define IMT_MISC_AUTO_FAN_BIT  4
`define IMT_MISC_UNUSED_BIT    5
`define IMT_MISC_CHASSIS_BIT   6
`define IMT_MISC_IO16_BIT      7

// writable bits of the misc mask
`define IMT_MISC_WMASK 8'hDF

`endif

// *** rtl/imt_pkg.sv ***
package imt_pkg;

    // one-hot register select
    typedef enum logic [6:0] {
        SEL_NONE    = 7'h01,
        SEL_FAN     = 7'h02,
        SEL_MISC    = 7'h04,
        SEL_IO_LOW  = 7'h08,
        SEL_IO_HIGH = 7'h10,
        SEL_TRIM    = 7'h20,
        SEL_READING = 7'h40
    } imt_sel_t;

endpackage

// *** rtl/imt_regs.sv ***
`timescale 1ns/1ps
`include "imt_map.svh"

module imt_regs #(
    parameter int FAN_N = 8,
    parameter int FAN_W = 8
) (
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire logic [7:0]             reg_addr,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [7:0]             reg_wdata,
    output logic      [7:0]             reg_rdata,
    input  wire logic                   fan_conv_done,
    input  wire logic [FAN_N*FAN_W-1:0] fan_tach_count,
    input  wire logic [FAN_N*FAN_W-1:0] fan_high_limit,
    input  wire logic                   die_temp_valid,
    input  wire logic [7:0]             die_temp_raw,
    input  wire logic [7:0]             die_temp_high_limit,
    input  wire logic [7:0]             die_temp_low_limit,
    input  wire logic                   battery_event,
    input  wire logic                   analog_input_8_event,
    input  wire logic                   overheat_event,
    input  wire logic                   auto_fan_event,
    input  wire logic                   chassis_open_input,
    input  wire logic [16:0]            io_line_event,
    output logic [FAN_N-1:0]            fan_flag,
    output logic                        die_temp_flag,
    output logic                        irq_out
);

    // address decode shared by read and write paths
    function automatic imt_pkg::imt_sel_t dec_sel(input logic [7:0] a);
        if (a == `IMT_FAN_MASK_ADDR) begin
            dec_sel = imt_pkg::SEL_FAN;
        end else if (a == `IMT_MISC_MASK_ADDR) begin
            dec_sel = imt_pkg::SEL_MISC;
        end else if (a == `IMT_IO_LOW_MASK_ADDR) begin
            dec_sel = imt_pkg::SEL_IO_LOW;
        end else if (a == `IMT_IO_HIGH_MASK_ADDR) begin
            dec_sel = imt_pkg::SEL_IO_HIGH;
        end else if (a == `IMT_TRIM_ADDR) begin
            dec_sel = imt_pkg::SEL_TRIM;
        end else if (a == `IMT_READING_ADDR) begin
            dec_sel = imt_pkg::SEL_READING;
        end else begin
            dec_sel = imt_pkg::SEL_NONE;
        end
    endfunction

    logic [7:0]       fan_mask_ff;
    logic [7:0]       misc_mask_ff;
    logic [7:0]       io_low_mask_ff;
    logic [7:0]       io_high_mask_ff;
    logic [7:0]       trim_ff;
    logic [7:0]       reading_ff;
    logic [7:0]       rdata_ff;
    logic [FAN_N-1:0] fan_flag_ff;
    logic             die_flag_ff;
    logic             irq_ff;

    logic [7:0]       nxt_fan_mask;
    logic [7:0]       nxt_misc_mask;
    logic [7:0]       nxt_io_low_mask;
    logic [7:0]       nxt_io_high_mask;
    logic [7:0]       nxt_trim;
    logic [7:0]       nxt_reading;
    logic [7:0]       nxt_rdata;
    logic [FAN_N-1:0] nxt_fan_flag;
    logic             nxt_die_flag;
    logic             nxt_irq;

    imt_pkg::imt_sel_t sel;
    logic [7:0]        die_adj;
    logic [7:0]        misc_src;
    logic [15:0]       io_mask;

    assign sel = dec_sel(reg_addr);

    // trim added first
    // two's complement sum wraps at 8 bits
    assign die_adj = die_temp_raw + trim_ff;

    // misc sources in mask bit order
    always_comb begin
        misc_src = 8'h00;
        misc_src[`IMT_MISC_DIE_TEMP_BIT] = die_flag_ff;
        misc_src[`IMT_MISC_BATTERY_BIT]  = battery_event;
        misc_src[`IMT_MISC_ANALOG_INPUT_8_BIT]     = analog_input_8_event;
        misc_src[`IMT_MISC_OVERHEAT_BIT] = overheat_event;
        misc_src[`IMT_MISC_AUTO_FAN_BIT] = auto_fan_event;
        misc_src[`IMT_MISC_CHASSIS_BIT]  = chassis_open_input;
        misc_src[`IMT_MISC_IO16_BIT]     = io_line_event[16];
    end

    // io lines 0-15, line 16 gates through misc
    assign io_mask = {io_high_mask_ff, io_low_mask_ff};

    // host writes to mask and trim registers
    always_comb begin
        nxt_fan_mask     = fan_mask_ff;
        nxt_misc_mask    = misc_mask_ff;
        nxt_io_low_mask  = io_low_mask_ff;
        nxt_io_high_mask = io_high_mask_ff;
        nxt_trim         = trim_ff;
        if (reg_wr) begin
            case (sel)
                imt_pkg::SEL_FAN: begin
                    nxt_fan_mask = reg_wdata;
                end
                imt_pkg::SEL_MISC: begin
                    nxt_misc_mask = reg_wdata & `IMT_MISC_WMASK;
                end
                imt_pkg::SEL_IO_LOW: begin
                    nxt_io_low_mask = reg_wdata;
                end
                imt_pkg::SEL_IO_HIGH: begin
                    nxt_io_high_mask = reg_wdata;
                end
                imt_pkg::SEL_TRIM: begin
                    nxt_trim = reg_wdata;
                end
                default: begin
                    nxt_trim = trim_ff; // reading is read-only
                end
            endcase
        end
    end

    // register read mux, one cycle latency
    always_comb begin
        nxt_rdata = rdata_ff;
        if (reg_rd) begin
            case (sel)
                imt_pkg::SEL_FAN:     nxt_rdata = fan_mask_ff;
                imt_pkg::SEL_MISC:    nxt_rdata = misc_mask_ff;
                imt_pkg::SEL_IO_LOW:  nxt_rdata = io_low_mask_ff;
                imt_pkg::SEL_IO_HIGH: nxt_rdata = io_high_mask_ff;
                imt_pkg::SEL_TRIM:    nxt_rdata = trim_ff;
                imt_pkg::SEL_READING: nxt_rdata = reading_ff;
                default:              nxt_rdata = `IMT_UNMAPPED_RD;
            endcase
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < FAN_N; gi++) begin : g_fan
            always_comb begin
                nxt_fan_flag[gi] = fan_flag_ff[gi];
                if (fan_conv_done) begin
                    nxt_fan_flag[gi] = fan_tach_count[gi*FAN_W +: FAN_W] >
                                       fan_high_limit[gi*FAN_W +: FAN_W];
                end
            end
        end
    endgenerate

    always_comb begin
        nxt_reading  = reading_ff;
        nxt_die_flag = die_flag_ff;
        if (die_temp_valid) begin
            nxt_reading = die_adj;
            nxt_die_flag = ($signed(die_adj) > $signed(die_temp_high_limit)) ||
                           ($signed(die_adj) < $signed(die_temp_low_limit));
        end
    end

    always_comb begin
        nxt_irq = (|(fan_flag_ff & ~fan_mask_ff[FAN_N-1:0])) ||
                  (|(misc_src & ~misc_mask_ff)) ||
                  (|(io_line_event[15:0] & ~io_mask[15:0]));
    end

    // state registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            fan_mask_ff     <= `IMT_MASK_RST;
            misc_mask_ff    <= `IMT_MASK_RST;
            io_low_mask_ff  <= `IMT_MASK_RST;
            io_high_mask_ff <= `IMT_MASK_RST;
            trim_ff         <= `IMT_TRIM_RST;
            reading_ff      <= `IMT_READING_RST;
            rdata_ff        <= `IMT_UNMAPPED_RD;
            fan_flag_ff     <= '0;
            die_flag_ff     <= 1'b0;
            irq_ff          <= 1'b0;
        end else begin
            fan_mask_ff     <= nxt_fan_mask;
            misc_mask_ff    <= nxt_misc_mask;
            io_low_mask_ff  <= nxt_io_low_mask;
            io_high_mask_ff <= nxt_io_high_mask;
            trim_ff         <= nxt_trim;
            reading_ff      <= nxt_reading;
            rdata_ff        <= nxt_rdata;
            fan_flag_ff     <= nxt_fan_flag;
            die_flag_ff     <= nxt_die_flag;
            irq_ff          <= nxt_irq;
        end
    end

    // outputs straight from flops
    assign reg_rdata     = rdata_ff;
    assign fan_flag      = fan_flag_ff;
    assign die_temp_flag = die_flag_ff;
    assign irq_out       = irq_ff;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_fan_mask_gate: assert property (
        fan_flag_ff[0] && !fan_mask_ff[0] |=> irq_ff)
        else $error("unmasked fan flag gave no irq");

    chk_die_mask_gate: assert property (
        die_flag_ff && !misc_mask_ff[`IMT_MISC_DIE_TEMP_BIT] |=> irq_ff)
        else $error("unmasked die temp flag gave no irq");

    chk_overheat_gate: assert property (
        overheat_event && !misc_mask_ff[`IMT_MISC_OVERHEAT_BIT] |=> irq_ff)
        else $error("unmasked overheat gave no irq");

    chk_auto_fan_gate: assert property (
        auto_fan_event && !misc_mask_ff[`IMT_MISC_AUTO_FAN_BIT] |=> irq_ff)
        else $error("unmasked auto fan event gave no irq");

    chk_unused_bit_zero: assert property (
        reg_rd && sel == imt_pkg::SEL_MISC
        |=> reg_rdata[`IMT_MISC_UNUSED_BIT] == 1'b0)
        else $error("misc unused bit read back nonzero");

    chk_chassis_gate: assert property (
        chassis_open_input && !misc_mask_ff[`IMT_MISC_CHASSIS_BIT] |=> irq_ff)
        else $error("unmasked chassis open gave no irq");

    chk_io16_gate: assert property (
        io_line_event[16] && !misc_mask_ff[`IMT_MISC_IO16_BIT] |=> irq_ff)
        else $error("unmasked io line 16 gave no irq");

    chk_io_low_gate: assert property (
        io_line_event[0] && !io_low_mask_ff[0] |=> irq_ff)
        else $error("unmasked io line 0 gave no irq");

    chk_io_high_gate: assert property (
        io_line_event[8] && !io_high_mask_ff[0] |=> irq_ff)
        else $error("unmasked io line 8 gave no irq");

    chk_mask_reset_zero: assert property (@(posedge clk) disable iff (1'b0)
        !resetn |=> (fan_mask_ff | misc_mask_ff | io_low_mask_ff | io_high_mask_ff) == 8'h00)
        else $error("mask not zero after reset");

    chk_fan_mask_rw: assert property (
        reg_wr && sel == imt_pkg::SEL_FAN
        |=> fan_mask_ff == $past(reg_wdata))
        else $error("fan mask differs from written byte");

    chk_trim_applied: assert property (
        die_temp_valid |=> reading_ff == 8'($past(die_temp_raw) + $past(trim_ff)))
        else $error("die reading not raw plus trim");

    chk_reading_hold: assert property (
        !die_temp_valid |=> $stable(reading_ff))
        else $error("die reading changed without conversion");

    chk_fan_limit: assert property (
        fan_conv_done |=> fan_flag_ff[0] ==
            ($past(fan_tach_count[FAN_W-1:0]) > $past(fan_high_limit[FAN_W-1:0])))
        else $error("fan flag disagrees with limit compare");

    chk_all_masked: assert property (
        fan_mask_ff == 8'hFF && misc_mask_ff == `IMT_MISC_WMASK &&
        io_low_mask_ff == 8'hFF && io_high_mask_ff == 8'hFF |=> !irq_ff)
        else $error("irq raised with every source masked");

    cov_irq_raise: cover property (!irq_ff ##1 irq_ff);
    cov_die_update: cover property (die_temp_valid ##1 die_temp_flag);
    cov_fan_flag: cover property (fan_conv_done ##1 (|fan_flag_ff));
    cov_misc_write: cover property (reg_wr && sel == imt_pkg::SEL_MISC);

endmodule

// *** dv/imt_host_model.sv ***
`timescale 1ns/1ps
module imt_host_model (
    input  wire logic       clk,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    // idle bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~d; // stale data is not held
    endtask
    // single-byte read, data one cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
endmodule

// *** dv/imt_regs_bench.sv ***
`timescale 1ns/1ps
`include "imt_map.svh"
module imt_regs_bench;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic        fan_done = 1'b0;
    logic [63:0] fan_cnt = '0;
    logic [63:0] fan_lim = '1;
    logic        die_valid = 1'b0;
    logic [7:0]  die_raw = 8'h00;
    logic [7:0]  die_hi = 8'h20;
    logic [7:0]  die_lo = 8'hF0;
    logic [21:0] src = '0;
    logic [7:0]  fan_flag;
    logic        die_temp_flag;
    logic        irq_out;
    int          n_fail = 0;
    int          n_compared = 0;

    // 125 MHz clock
    always #4 clk = ~clk;

    imt_host_model imt_host_model_i (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    imt_regs imt_regs_i (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fan_conv_done(fan_done), .fan_tach_count(fan_cnt),
        .fan_high_limit(fan_lim), .die_temp_valid(die_valid), .die_temp_raw(die_raw),
        .die_temp_high_limit(die_hi), .die_temp_low_limit(die_lo), .battery_event(src[17]),
        .analog_input_8_event(src[18]), .overheat_event(src[19]), .auto_fan_event(src[20]),
        .chassis_open_input(src[21]), .io_line_event(src[16:0]), .fan_flag(fan_flag),
        .die_temp_flag(die_temp_flag), .irq_out(irq_out));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // one-cycle conversion pulse, fan or on-die
    task automatic conv(input bit die);
        if (die)
            die_valid = 1'b1;
        else
            fan_done = 1'b1;
        @(negedge clk);
        die_valid = 1'b0;
        fan_done = 1'b0;
    endtask

    // mask register and bit that guard each event source
    function automatic logic [7:0] src_addr(input int i);
        if (i < 8)
            return `IMT_IO_LOW_MASK_ADDR;
        if (i < 16)
            return `IMT_IO_HIGH_MASK_ADDR;
        return `IMT_MISC_MASK_ADDR;
    endfunction
    function automatic int src_bit(input int i);
        int mb [6] = '{7, 1, 2, 3, 4, 6};
        if (i < 16)
            return i % 8;
        return mb[i-16];
    endfunction

    // main sequence
    initial begin
        logic [7:0] d;
        logic [7:0] v;
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        for (int i = 8'h1A; i <= 8'h20; i++) begin
            imt_host_model_i.rd(i[7:0], d);
            chk(d, 8'h00);
        end
        chk({7'h0, irq_out}, 8'h00);
        $display("test reset_values done");
        for (int i = 8'h1A; i <= 8'h20; i++)
            imt_host_model_i.wr(i[7:0], 8'hA5 ^ i[7:0]);
        for (int i = 8'h1A; i <= 8'h20; i++) begin
            v = 8'hA5 ^ i[7:0];
            imt_host_model_i.rd(i[7:0], d);
            chk(d, i == 8'h1B ? v & 8'hDF : (i >= 8'h1F ? 8'h00 : v));
            imt_host_model_i.wr(i[7:0], 8'h00);
        end
        $display("test read_write done");
        for (int i = 0; i < 22; i++) begin
            src[i] = 1'b1;
            @(negedge clk);
            chk({7'h0, irq_out}, 8'h01);
            imt_host_model_i.wr(src_addr(i), 8'h01 << src_bit(i));
            @(negedge clk);
            chk({7'h0, irq_out}, 8'h00);
            src[i] = 1'b0;
            imt_host_model_i.wr(src_addr(i), 8'h00);
        end
        // every src event line active, every mask set
        src = '1;
        for (int i = 8'h1A; i <= 8'h1D; i++)
            imt_host_model_i.wr(i[7:0], 8'hFF);
        @(negedge clk);
        chk({7'h0, irq_out}, 8'h00);
        src = '0;
        for (int i = 8'h1A; i <= 8'h1D; i++)
            imt_host_model_i.wr(i[7:0], 8'h00);
        $display("test source_masks done");
        for (int i = 0; i < 8; i++) begin
            fan_cnt[8*i +: 8] = 8'h80;
            fan_lim[8*i +: 8] = i[0] ? 8'h80 : 8'h7F;
        end
        conv(1'b0);
        chk(fan_flag, 8'h55);
        @(negedge clk);
        chk({7'h0, irq_out}, 8'h01);
        imt_host_model_i.wr(`IMT_FAN_MASK_ADDR, 8'h55);
        @(negedge clk);
        chk({7'h0, irq_out}, 8'h00);
        imt_host_model_i.wr(`IMT_FAN_MASK_ADDR, 8'h54);
        @(negedge clk);
        chk({7'h0, irq_out}, 8'h01);
        fan_cnt = '0;
        conv(1'b0);
        chk(fan_flag, 8'h00);
        $display("test fan_flags done");
        imt_host_model_i.wr(`IMT_TRIM_ADDR, 8'hFE);
        die_raw = 8'h10;
        conv(1'b1);
        chk({7'h0, die_temp_flag}, 8'h00);
        imt_host_model_i.rd(`IMT_READING_ADDR, d);
        chk(d, 8'h0E);
        imt_host_model_i.wr(`IMT_TRIM_ADDR, 8'h7F);
        die_raw = 8'hA2;
        conv(1'b1);
        chk({7'h0, die_temp_flag}, 8'h01);
        @(negedge clk);
        chk({7'h0, irq_out}, 8'h01);
        imt_host_model_i.wr(`IMT_MISC_MASK_ADDR, 8'h01);
        @(negedge clk);
        chk({7'h0, irq_out}, 8'h00);
        imt_host_model_i.wr(`IMT_READING_ADDR, 8'h55);
        imt_host_model_i.rd(`IMT_READING_ADDR, d);
        chk(d, 8'h21);
        // negative trim pushes reading below the low limit
        imt_host_model_i.wr(`IMT_TRIM_ADDR, 8'hD0);
        die_raw = 8'h10;
        conv(1'b1);
        chk({7'h0, die_temp_flag}, 8'h01);
        imt_host_model_i.rd(`IMT_READING_ADDR, d);
        chk(d, 8'hE0);
        $display("test die_temp done");
        imt_host_model_i.wr(`IMT_FAN_MASK_ADDR, 8'h3C);
        resetn = 1'b0;
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        imt_host_model_i.rd(`IMT_FAN_MASK_ADDR, d);
        chk(d, 8'h00);
        imt_host_model_i.rd(`IMT_READING_ADDR, d);
        chk(d, 8'h00);
        $display("test second_reset done");
        final_report();
    end

    // watchdog well beyond the expected run length
    initial begin
        #200000;
        n_fail++;
        final_report();
    end
endmodule
